// >>> common/bcj_consts.svh
// constants for the bit-clear and jump execution block
`ifndef BCJ_CONSTS_SVH
`define BCJ_CONSTS_SVH

// clocks per T-state (200 MHz core, 50 MHz T-state)
`define BCJ_TSTATE_DIV 8'h04

// opcodes and fields
`define BCJ_OP_PREFIX_BIT 8'hCB
`define BCJ_OP_PREFIX_IX 8'hDD
`define BCJ_OP_PREFIX_IY 8'hFD
`define BCJ_OP_JP 8'hC3
`define BCJ_OP_JR 8'h18
`define BCJ_OP_JR_C 8'h38
`define BCJ_OP_JR_NC 8'h30
`define BCJ_GRP_BIT_CLEAR 2'h2
`define BCJ_GRP_JP_COND 2'h3
`define BCJ_LOW_JP_COND 3'h2
`define BCJ_REG_MEMORY 3'h6
`define BCJ_REG_H 3'h4
`define BCJ_REG_L 3'h5

// flag positions inside the flag byte
`define BCJ_FLAG_S 7
`define BCJ_FLAG_Z 6
`define BCJ_FLAG_PV 2
`define BCJ_FLAG_C 0

// machine cycle lengths in T-states
`define BCJ_T_OPF 3'h4
`define BCJ_T_READ3 3'h3
`define BCJ_T_INT5 3'h5
`define BCJ_T_MRD 3'h4
`define BCJ_T_MWR 3'h3

// register port addresses
`define BCJ_ADDR_CTRL 4'h0
`define BCJ_ADDR_STATUS 4'h1
`define BCJ_ADDR_REG_BASE 4'h2
`define BCJ_ADDR_REG_LAST 4'h9
`define BCJ_ADDR_PC_LO 4'hA
`define BCJ_ADDR_PC_HI 4'hB
`define BCJ_ADDR_IX_LO 4'hC
`define BCJ_ADDR_IX_HI 4'hD
`define BCJ_ADDR_IY_LO 4'hE
`define BCJ_ADDR_IY_HI 4'hF
`define BCJ_CTRL_RUN 0
`define BCJ_STAT_BUSY 0
`define BCJ_STAT_UNSUP 1

// reset values
`define BCJ_RST_BYTE 8'h00
`define BCJ_RST_WORD 16'h0000
`define BCJ_RST_T 3'h0

`endif

// >>> common/bcj_pkg.sv
// types for the bit-clear and jump execution block
package bcj_pkg;

  typedef enum logic [3:0] {
    MC_IDLE,
    MC_OPF,
    MC_CBF,
    MC_IXCB,
    MC_DISP,
    MC_XOP,
    MC_IMM_LO,
    MC_IMM_HI,
    MC_JR_DISP,
    MC_JR_ADD,
    MC_MRD,
    MC_MWR
  } bcj_mc_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } bcj_tick_t;

  typedef struct packed {
    bcj_mc_t mc;
    logic [2:0] tcnt;
    logic [15:0] pc;
    logic [7:0][7:0] regs;
    logic [15:0] ix;
    logic [15:0] iy;
    logic run;
    logic unsup;
    logic idx_sel;
    logic [7:0] opc;
    logic [7:0] disp;
    logic [7:0] lo;
    logic [15:0] ea;
    logic [7:0] mdata;
    logic [15:0] mem_addr;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] mem_wdata;
    logic [7:0] rdata;
    logic busy;
  } bcj_state_t;

endpackage

// >>> logic/bcj_bit_clear.sv
// clears one selected bit of a byte
`timescale 1ns/1ps
module bcj_bit_clear (
  input wire logic [7:0] data_in,
  input wire logic [2:0] bit_sel_in,
  output logic [7:0] data_out
);
  import bcj_pkg::*;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      // only the selected position is forced low
      assign data_out[i] = data_in[i] & (bit_sel_in != 3'(i));
    end
  endgenerate
endmodule

// >>> logic/bcj_tick.sv
// T-state enable divider
`timescale 1ns/1ps
`include "bcj_consts.svh"
module bcj_tick (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  output logic tick_out
);
  import bcj_pkg::*;

  bcj_tick_t q, d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == `BCJ_TSTATE_DIV - 8'h01) begin
      d.cnt = `BCJ_RST_BYTE;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_out = q.tick;
endmodule

// >>> logic/bcj_top.sv
// bit-clear and jump execution core with register port
`timescale 1ns/1ps
`include "bcj_consts.svh"
module bcj_top (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [7:0] mem_rdata_in,
  output logic [15:0] mem_addr_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [7:0] mem_wdata_out,
  output logic busy_out
);
  import bcj_pkg::*;

  bcj_state_t q, d;
  logic tick;
  logic [7:0] clr_src;
  logic [2:0] clr_bit;
  logic [7:0] clr_res;

  bcj_tick u_tick (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .tick_out(tick)
  );

  bcj_bit_clear u_clr (
    .data_in(clr_src),
    .bit_sel_in(clr_bit),
    .data_out(clr_res)
  );

  function automatic logic [2:0] mc_len(input bcj_mc_t mc);
    unique case (mc)
      MC_IDLE: mc_len = `BCJ_T_OPF;
      MC_OPF: mc_len = `BCJ_T_OPF;
      MC_CBF: mc_len = `BCJ_T_OPF;
      MC_IXCB: mc_len = `BCJ_T_OPF;
      MC_DISP: mc_len = `BCJ_T_READ3;
      MC_XOP: mc_len = `BCJ_T_INT5;
      MC_IMM_LO: mc_len = `BCJ_T_READ3;
      MC_IMM_HI: mc_len = `BCJ_T_READ3;
      MC_JR_DISP: mc_len = `BCJ_T_READ3;
      MC_JR_ADD: mc_len = `BCJ_T_INT5;
      MC_MRD: mc_len = `BCJ_T_MRD;
      MC_MWR: mc_len = `BCJ_T_MWR;
    endcase
  endfunction

  // condition field against the flag byte
  function automatic logic cond_true(input logic [2:0] cc, input logic [7:0] f);
    logic flag;
    unique case (cc[2:1])
      2'h0: flag = f[`BCJ_FLAG_Z];
      2'h1: flag = f[`BCJ_FLAG_C];
      2'h2: flag = f[`BCJ_FLAG_PV];
      2'h3: flag = f[`BCJ_FLAG_S];
    endcase
    cond_true = (flag == cc[0]);
  endfunction

  // opcode byte of the register form arrives on the bus; memory forms use the saved byte
  always_comb begin
    if (q.mc == MC_CBF) begin
      clr_src = q.regs[mem_rdata_in[2:0]];
      clr_bit = mem_rdata_in[5:3];
    end else begin
      clr_src = mem_rdata_in;
      clr_bit = q.opc[5:3];
    end
  end

  always_comb begin
    bcj_mc_t next_op;
    logic [15:0] pc_inc;
    logic [15:0] idx;
    next_op = q.run ? MC_OPF : MC_IDLE;
    pc_inc = q.pc + 16'h0001;
    idx = q.idx_sel ? q.iy : q.ix;
    d = q;

    // register port: read data valid only in the cycle after the strobe
    d.rdata = `BCJ_RST_BYTE;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `BCJ_ADDR_CTRL: d.rdata = {7'h00, q.run};
        `BCJ_ADDR_STATUS: d.rdata = {6'h00, q.unsup, q.mc != MC_IDLE};
        `BCJ_ADDR_PC_LO: d.rdata = q.pc[7:0];
        `BCJ_ADDR_PC_HI: d.rdata = q.pc[15:8];
        `BCJ_ADDR_IX_LO: d.rdata = q.ix[7:0];
        `BCJ_ADDR_IX_HI: d.rdata = q.ix[15:8];
        `BCJ_ADDR_IY_LO: d.rdata = q.iy[7:0];
        `BCJ_ADDR_IY_HI: d.rdata = q.iy[15:8];
        default: d.rdata = q.regs[3'(reg_addr_in - `BCJ_ADDR_REG_BASE)];
      endcase
    end
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `BCJ_ADDR_CTRL: d.run = reg_wdata_in[`BCJ_CTRL_RUN];
        `BCJ_ADDR_STATUS: begin
          if (reg_wdata_in[`BCJ_STAT_UNSUP]) begin
            d.unsup = 1'b0;
          end
        end
        `BCJ_ADDR_PC_LO: d.pc[7:0] = reg_wdata_in;
        `BCJ_ADDR_PC_HI: d.pc[15:8] = reg_wdata_in;
        `BCJ_ADDR_IX_LO: d.ix[7:0] = reg_wdata_in;
        `BCJ_ADDR_IX_HI: d.ix[15:8] = reg_wdata_in;
        `BCJ_ADDR_IY_LO: d.iy[7:0] = reg_wdata_in;
        `BCJ_ADDR_IY_HI: d.iy[15:8] = reg_wdata_in;
        default: d.regs[3'(reg_addr_in - `BCJ_ADDR_REG_BASE)] = reg_wdata_in;
      endcase
    end

    // sequencer: one step per T-state, action on the last T-state of a machine cycle
    if (q.mc == MC_IDLE) begin
      if (q.run) begin
        d.mc = MC_OPF;
        d.tcnt = `BCJ_RST_T;
      end
    end else if (tick) begin
      if (q.tcnt != mc_len(q.mc) - 3'h1) begin
        d.tcnt = q.tcnt + 3'h1;
      end else begin
        d.tcnt = `BCJ_RST_T;
        unique case (q.mc)
          MC_OPF: begin
            d.pc = pc_inc;
            d.opc = mem_rdata_in;
            if (mem_rdata_in == `BCJ_OP_PREFIX_BIT) begin
              d.mc = MC_CBF;
            end else if (mem_rdata_in == `BCJ_OP_PREFIX_IX ||
                         mem_rdata_in == `BCJ_OP_PREFIX_IY) begin
              d.idx_sel = (mem_rdata_in == `BCJ_OP_PREFIX_IY);
              d.mc = MC_IXCB;
            end else if (mem_rdata_in == `BCJ_OP_JP ||
                         (mem_rdata_in[7:6] == `BCJ_GRP_JP_COND &&
                          mem_rdata_in[2:0] == `BCJ_LOW_JP_COND)) begin
              d.mc = MC_IMM_LO;
            end else if (mem_rdata_in == `BCJ_OP_JR ||
                         mem_rdata_in == `BCJ_OP_JR_C ||
                         mem_rdata_in == `BCJ_OP_JR_NC) begin
              d.mc = MC_JR_DISP;
            end else begin
              // anything outside this block's groups runs as a 4 T-state no-op
              d.unsup = 1'b1;
              d.mc = next_op;
            end
          end
          MC_CBF: begin
            d.pc = pc_inc;
            d.opc = mem_rdata_in;
            if (mem_rdata_in[7:6] != `BCJ_GRP_BIT_CLEAR) begin
              d.unsup = 1'b1;
              d.mc = next_op;
            end else if (mem_rdata_in[2:0] == `BCJ_REG_MEMORY) begin
              d.ea = {q.regs[`BCJ_REG_H], q.regs[`BCJ_REG_L]};
              d.mc = MC_MRD;
            end else begin
              // register form ends here after 4+4 T-states
              d.regs[mem_rdata_in[2:0]] = clr_res;
              d.mc = next_op;
            end
          end
          MC_IXCB: begin
            d.pc = pc_inc;
            if (mem_rdata_in == `BCJ_OP_PREFIX_BIT) begin
              d.mc = MC_DISP;
            end else begin
              d.unsup = 1'b1;
              d.mc = next_op;
            end
          end
          MC_DISP: begin
            d.pc = pc_inc;
            d.disp = mem_rdata_in;
            d.mc = MC_XOP;
          end
          MC_XOP: begin
            d.pc = pc_inc;
            d.opc = mem_rdata_in;
            // index plus signed displacement
            d.ea = idx + {{8{q.disp[7]}}, q.disp};
            if (mem_rdata_in[7:6] == `BCJ_GRP_BIT_CLEAR &&
                mem_rdata_in[2:0] == `BCJ_REG_MEMORY) begin
              d.mc = MC_MRD; // 4+4+3+5 then 4+3 T-states
            end else begin
              d.unsup = 1'b1;
              d.mc = next_op;
            end
          end
          MC_MRD: begin
            d.mdata = clr_res;
            d.mc = MC_MWR;
          end
          MC_MWR: begin
            // flags are never written by the memory forms
            d.mc = next_op;
          end
          MC_IMM_LO: begin
            d.pc = pc_inc;
            d.lo = mem_rdata_in; // low byte first
            d.mc = MC_IMM_HI;
          end
          MC_IMM_HI: begin
            // 4+3+3 T-states whether or not the jump is taken
            if (q.opc == `BCJ_OP_JP ||
                cond_true(q.opc[5:3], q.regs[`BCJ_REG_MEMORY])) begin
              d.pc = {mem_rdata_in, q.lo};
            end else begin
              d.pc = pc_inc;
            end
            d.mc = next_op;
          end
          MC_JR_DISP: begin
            d.pc = pc_inc;
            d.disp = mem_rdata_in;
            if (q.opc == `BCJ_OP_JR ||
                (q.opc == `BCJ_OP_JR_C && q.regs[`BCJ_REG_MEMORY][`BCJ_FLAG_C]) ||
                (q.opc == `BCJ_OP_JR_NC && !q.regs[`BCJ_REG_MEMORY][`BCJ_FLAG_C])) begin
              d.mc = MC_JR_ADD;
            end else begin
              d.mc = next_op; // not taken after 4+3 T-states
            end
          end
          MC_JR_ADD: begin
            // pc already points past both bytes, so the stored byte is offset minus two
            d.pc = q.pc + {{8{q.disp[7]}}, q.disp};
            d.mc = next_op; // taken after 4+3+5 T-states
          end
          default: d.mc = MC_IDLE;
        endcase
      end
    end

    // bus outputs follow the machine cycle being entered
    d.mem_rd = (d.mc != MC_IDLE) && (d.mc != MC_JR_ADD) && (d.mc != MC_MWR);
    d.mem_wr = (d.mc == MC_MWR);
    d.mem_addr = (d.mc == MC_MRD || d.mc == MC_MWR) ? d.ea : d.pc;
    d.mem_wdata = d.mdata;
    d.busy = (d.mc != MC_IDLE);
    if (d.mc == MC_IDLE) begin
      d.mem_rd = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_out = q.rdata;
  assign mem_addr_out = q.mem_addr;
  assign mem_rd_out = q.mem_rd;
  assign mem_wr_out = q.mem_wr;
  assign mem_wdata_out = q.mem_wdata;
  assign busy_out = q.busy;
endmodule

// >>> verification/bcj_mem_model.sv
// program and data memory at the core's far side
`timescale 1ns/1ps
module bcj_mem_model (
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic [15:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [65536];
  logic [7:0] last_q = 8'h00;
  logic [15:0] addr_q = 16'h0000;
  logic [1:0] age_q = 2'h0;
  // unselected or unsettled: toggling junk, so stale data never passes
  assign rdata_out = (rd_in && (!slow_in || age_q == 2'h3)) ? mem[addr_in] : ~last_q;
  always @(posedge clk_in) begin
    last_q <= rdata_out;
    addr_q <= addr_in;
    if (!rd_in || addr_in != addr_q) age_q <= 2'h0;
    else if (age_q != 2'h3) age_q <= age_q + 2'h1;
    if (wr_in) mem[addr_in] <= wdata_in;
  end
endmodule

// >>> verification/bcj_top_monitor.sv
// concurrent checks on the core's memory port
`timescale 1ns/1ps
module bcj_top_monitor (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic [15:0] mem_addr_out,
  input wire logic mem_rd_out,
  input wire logic mem_wr_out,
  input wire logic [7:0] mem_wdata_out,
  input wire logic busy_out
);
  logic [7:0] wr_cnt_q;
  logic [7:0] gap_q;
  logic [7:0] cap_q;
  logic gap;
  assign gap = busy_out && !mem_rd_out && !mem_wr_out;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  // run lengths of the write cycle and of the bus-quiet add cycle
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_cnt_q <= 8'h00;
      gap_q <= 8'h00;
      cap_q <= 8'h00;
    end else begin
      wr_cnt_q <= mem_wr_out ? wr_cnt_q + 8'h01 : 8'h00;
      gap_q <= gap ? gap_q + 8'h01 : 8'h00;
      cap_q <= mem_rd_out ? mem_rdata_in : cap_q;
    end
  end
  property p_excl; !(mem_rd_out && mem_wr_out); endproperty
  a_excl: assert property (p_excl) else $error("read and write at once");
  property p_busy; mem_rd_out || mem_wr_out |-> busy_out; endproperty
  a_busy: assert property (p_busy) else $error("memory cycle while idle");
  property p_wr_len; !mem_wr_out && wr_cnt_q != 8'h00 |-> wr_cnt_q == 8'h0C; endproperty
  a_wr_len: assert property (p_wr_len) else $error("write cycle length");
  property p_wr_hold;
    mem_wr_out && $past(mem_wr_out) |-> $stable(mem_wdata_out) && $stable(mem_addr_out);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write moved");
  property p_rmw; $rose(mem_wr_out) |-> $past(mem_rd_out) && $stable(mem_addr_out); endproperty
  a_rmw: assert property (p_rmw) else $error("write not at read address");
  property p_clear;
    $rose(mem_wr_out) |-> (mem_wdata_out & ~cap_q) == 8'h00 && $onehot0(mem_wdata_out ^ cap_q);
  endproperty
  a_clear: assert property (p_clear) else $error("written byte not read byte");
  property p_add_len; gap_q > 8'h04 && !gap |-> gap_q == 8'h14; endproperty
  a_add_len: assert property (p_add_len) else $error("add cycle length");
  property p_add_max; gap_q <= 8'h14; endproperty
  a_add_max: assert property (p_add_max) else $error("add cycle too long");
  c_rmw: cover property ($rose(mem_wr_out));
  c_add: cover property (gap_q == 8'h14);
  c_end: cover property ($fell(busy_out));
endmodule

bind bcj_top bcj_top_monitor u_mon (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
  .mem_rdata_in(mem_rdata_in), .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
  .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out), .busy_out(busy_out));

// >>> verification/bit_clear_and_jump_exec_tb.sv
// self-checking bench for the bit-clear and jump core
`timescale 1ns/1ps
module bit_clear_and_jump_exec_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] ra = 4'h0;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic slow = 1'b0;
  logic [7:0] rdat, mrd, mwd;
  logic [15:0] ma;
  logic mr, mw, busy;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;

  bcj_top DUT (.sys_clk_in(clk), .resetn_in(rst_n), .reg_addr_in(ra), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .mem_rdata_in(mrd),
    .mem_addr_out(ma), .mem_rd_out(mr), .mem_wr_out(mw), .mem_wdata_out(mwd),
    .busy_out(busy));
  bcj_mem_model u_mem (.clk_in(clk), .slow_in(slow), .addr_in(ma), .rd_in(mr),
    .wr_in(mw), .wdata_in(mwd), .rdata_out(mrd));

  always #2.5 clk = ~clk;

  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic w16(input logic [3:0] a, input logic [15:0] v);
    wreg(a, v[7:0]);
    wreg(a + 4'h1, v[15:8]);
  endtask

  task automatic rreg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdat;
  endtask

  function automatic logic [15:0] rel(input logic [15:0] pc, input logic [7:0] d);
    return pc + 16'h0002 + {{8{d[7]}}, d};
  endfunction

  function automatic logic cc_true(input logic [2:0] cc, input logic [7:0] f);
    logic [3:0] pick;
    pick = {f[7], f[2], f[0], f[6]};
    return pick[cc[2:1]] == cc[0];
  endfunction

  // one instruction from a run pulse; busy span is the length, first T-state may be short
  task automatic exec(input int t, input logic [15:0] epc, input logic [7:0] f);
    int n;
    logic [7:0] lo;
    logic [7:0] hi;
    n = 0;
    @(posedge clk);
    ra <= 4'h0;
    wd <= 8'h01;
    wr <= 1'b1;
    @(posedge clk);
    wd <= 8'h00;
    @(posedge clk);
    wr <= 1'b0;
    #1;
    for (int i = 0; i < 4 && busy !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    while (busy === 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(16'(n > 4 * t - 4 && n <= 4 * t), 16'h0001);
    rreg(4'hA, lo);
    rreg(4'hB, hi);
    check({hi, lo}, epc);
    rreg(4'h8, lo);
    check(lo, f);
  endtask

  initial begin
    logic [15:0] pc, ea, tg, epc;
    logic [7:0] f, v, d, x;
    logic [7:0] op [4];
    logic [2:0] b, r;
    logic tk;
    int t;
    void'($urandom(32'hD0AE362C));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 64; k++) begin
      pc = 16'($urandom);
      ea = pc ^ 16'h8000;
      tg = 16'($urandom);
      f = 8'($urandom);
      v = 8'($urandom);
      d = (k < 8) ? 8'h80 : (k < 16) ? 8'h7F : 8'($urandom);
      b = 3'($urandom);
      r = (k > 47) ? 3'h7 : 3'(k / 8);
      slow <= k[1];
      op = '{8'hCB, {2'h2, b, 3'h6}, d, {2'h2, b, 3'h6}};
      epc = pc + 16'h0002;
      case (k % 8)
        0: begin
          op[1][2:0] = r;
          wreg(4'h2 + 4'(r), v);
          t = 8;
        end
        1: begin
          wreg(4'h6, ea[15:8]);
          wreg(4'h7, ea[7:0]);
          t = 15;
        end
        2, 3: begin
          op[0] = (k % 8 == 2) ? 8'hDD : 8'hFD;
          op[1] = 8'hCB;
          w16((k % 8 == 2) ? 4'hC : 4'hE, ea - {{8{d[7]}}, d});
          epc = pc + 16'h0004;
          t = 23;
        end
        4, 5: begin
          op = '{(k % 8 == 4) ? 8'hC3 : {2'h3, 3'(k / 8), 3'h2}, tg[7:0], tg[15:8], 8'h00};
          tk = (k % 8 == 4) || cc_true(3'(k / 8), f);
          epc = tk ? tg : pc + 16'h0003;
          t = 10;
        end
        default: begin
          op[0] = (k % 8 == 6) ? 8'h18 : k[3] ? 8'h38 : 8'h30;
          op[1] = d;
          if (k % 8 == 7) f[0] = k[4];
          tk = (k % 8 == 6) || (f[0] == k[3]);
          epc = tk ? rel(pc, d) : epc;
          t = tk ? 12 : 7;
        end
      endcase
      u_mem.mem[ea] = v;
      for (int i = 0; i < 4; i++) u_mem.mem[pc + 16'(i)] = op[i];
      w16(4'hA, pc);
      wreg(4'h8, f);
      exec(t, epc, f);
      if (k % 8 == 0) begin
        rreg(4'h2 + 4'(r), x);
        check(x, v & ~(8'h01 << b));
      end else if (k % 8 < 4) begin
        check(u_mem.mem[ea], v & ~(8'h01 << b));
      end
    end
    // opcode outside both groups: one fetch, sticky status, write-one clear
    u_mem.mem[16'h1234] = 8'h00;
    w16(4'hA, 16'h1234);
    exec(4, 16'h1235, f);
    rreg(4'h1, x);
    check(x, 8'h02);
    wreg(4'h1, 8'h02);
    rreg(4'h1, x);
    check(x, 8'h00);
    conclude();
  end
endmodule
